// File: verilog/cfgreg_pkg.sv
// Shared constants for the configuration register bank
package cfgreg_pkg;
  // Register indices reached through the data port
  localparam logic [7:0] IDX_UART_IR = 8'h0c;
  localparam logic [7:0] IDX_IR_PIN = 8'h0d;
  localparam logic [7:0] IDX_TEST_A = 8'h0e;
  localparam logic [7:0] IDX_TEST_B = 8'h0f;
  localparam logic [7:0] IDX_GP0_LO = 8'h10;
  localparam logic [7:0] IDX_GP0_HI = 8'h11;
  localparam logic [7:0] IDX_GP1_LO = 8'h12;
  localparam logic [7:0] IDX_GP1_HI = 8'h13;
  localparam logic [7:0] IDX_GP0_MODE = 8'h14;
  // Values after reset
  localparam logic [7:0] RST_UART_IR = 8'h28;
  localparam logic [7:0] RST_IR_PIN = 8'ha3;
  localparam logic [7:0] RST_GP = 8'h00;
  // Synchroniser reset values hold every pin at its idle level
  localparam logic [26:0] RST_PIN_SYNC = 27'h00000c0;
  localparam logic [1:0] RST_AUX_SYNC = 2'h1;
  // Cycles until the strap has passed the synchroniser
  localparam logic [1:0] STRAP_WAIT = 2'h2;
  // Writable bits; reserved bits read as zero
  localparam logic [7:0] MASK_UART_IR = 8'hfb;
  localparam logic [7:0] MASK_GP_HI = 8'hc7;
  // Field positions
  localparam int B_UART_A_FAST = 7;
  localparam int B_UART_B_FAST = 6;
  localparam int B_KEY_SEL = 5;
  localparam int B_BANK_PRI = 4;
  localparam int B_ROLE = 3;
  localparam int B_RX_INV = 1;
  localparam int B_TX_INV = 0;
  localparam int B_HALF_DUP = 3;
  // Unlock keys and ports
  localparam logic [10:0] PORT_LOW = 11'h250;
  localparam logic [10:0] PORT_HIGH = 11'h3f0;
  localparam logic [7:0] KEY_00 = 8'h88;
  localparam logic [7:0] KEY_01 = 8'h89;
  localparam logic [7:0] KEY_10 = 8'h86;
  localparam logic [7:0] KEY_11 = 8'h87;
  localparam logic [7:0] KEY_EXIT = 8'haa;
  // Infrared modes
  localparam logic [2:0] IRM_PULSE_FIX = 3'b010;
  localparam logic [2:0] IRM_PULSE_316 = 3'b011;
  // Timing
  localparam int CLK_NS = 20;
  localparam int IR_PULSE_NS = 1600;
  localparam int IR_PULSE_CYC = (IR_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CARRIER_HALF_NS = 1000;
  localparam int CARRIER_HALF_CYC = CARRIER_HALF_NS / CLK_NS;
  localparam logic [7:0] PULSE_316_TICKS = 8'h03;
  localparam logic [4:0] DEMOD_HOLD_TICKS = 5'h10;
endpackage : cfgreg_pkg

// File: verilog/cfgreg_top.sv
// Configuration register bank with infrared routing and decoded pins
module cfgreg_top (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic [10:0] SA_I,
  input wire logic [7:0] SD_I,
  output logic [7:0] SD_O,
  output logic [7:0] SD_OE_N_O,
  input wire logic IOR_N_I,
  input wire logic IOW_N_I,
  input wire logic AEN_I,
  input wire logic UNLOCK_PORT_SELECT_I,
  input wire logic CONFIG_LOCK_I,
  input wire logic [7:0] GP_ONE_MODE_I,
  input wire logic [1:0] GP_PIN_I,
  output logic [1:0] GP_PIN_O,
  output logic [1:0] GP_PIN_OE_N_O,
  output logic UART_A_FAST_CLOCK_SEL_O,
  output logic UART_B_FAST_CLOCK_SEL_O,
  input wire logic [2:0] BANK_IR_MODE_I,
  input wire logic BAUD_X16_TICK_I,
  input wire logic SECOND_SERIAL_OUT_I,
  output logic SECOND_SERIAL_IN_O,
  input wire logic SERIAL_IN_PIN_I,
  output logic SERIAL_OUT_PIN_O,
  input wire logic [1:0] INFRARED_RECEIVE_IN_I,
  output logic [1:0] INFRARED_TRANSMIT_OUT_O,
  output logic [1:0] INFRARED_TRANSMIT_OE_N_O
);

  // Two-flop synchronisers for every pin from the ISA side and IR pins
  logic [26:0] pin_m_r;
  logic [26:0] pin_s_r;
  logic iow_d_r;
  logic [10:0] sa_s;
  logic [7:0] sd_s;
  logic ior_s;
  logic iow_s;
  logic aen_s;
  logic strap_s;
  logic lock_s;
  logic [1:0] gpin_s;
  logic [1:0] infrared_receive_in_s;
  logic sin_s;
  logic wr_edge;

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      // Strobes reset idle high so release makes no false write edge
      pin_m_r <= cfgreg_pkg::RST_PIN_SYNC;
      pin_s_r <= cfgreg_pkg::RST_PIN_SYNC;
      iow_d_r <= 1'b1;
    end else begin
      pin_m_r <= {SA_I, SD_I, IOR_N_I, IOW_N_I, AEN_I, UNLOCK_PORT_SELECT_I,
                  CONFIG_LOCK_I, GP_PIN_I, INFRARED_RECEIVE_IN_I[0]};
      pin_s_r <= pin_m_r;
      iow_d_r <= iow_s;
    end
  end

  assign {sa_s, sd_s, ior_s, iow_s, aen_s, strap_s, lock_s, gpin_s} =
    pin_s_r[26:1];
  // Second IR receive and serial input pins share one small synchroniser
  logic [1:0] aux_m_r;
  logic [1:0] aux_s_r;
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      // Serial input resets to its idle high, so no false start bit
      aux_m_r <= cfgreg_pkg::RST_AUX_SYNC;
      aux_s_r <= cfgreg_pkg::RST_AUX_SYNC;
    end else begin
      aux_m_r <= {INFRARED_RECEIVE_IN_I[1], SERIAL_IN_PIN_I};
      aux_s_r <= aux_m_r;
    end
  end
  assign infrared_receive_in_s = {aux_s_r[1], pin_s_r[0]};
  assign sin_s = aux_s_r[0];
  // Write strobe falling edge; data is stable around the strobe
  assign wr_edge = iow_d_r & ~iow_s & ~aen_s;

  // Strap is caught once the synchroniser holds the pin, never its reset
  logic [1:0] strap_cnt_r;
  logic port_sel_r;
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      strap_cnt_r <= 2'h0;
      port_sel_r <= 1'b0;
    end else if (strap_cnt_r != 2'h3) begin
      strap_cnt_r <= 2'(strap_cnt_r + 2'h1);
      if (strap_cnt_r == cfgreg_pkg::STRAP_WAIT) begin
        port_sel_r <= strap_s;
      end
    end
  end

  // Configuration registers
  logic [7:0] reg_uart_ir_r;
  logic [7:0] reg_ir_pin_r;
  logic [7:0] reg_gp0_lo_r;
  logic [7:0] reg_gp0_hi_r;
  logic [7:0] reg_gp1_lo_r;
  logic [7:0] reg_gp1_hi_r;
  logic [7:0] reg_gp0_mode_r;
  logic [7:0] index_r;
  logic unlocked_r;
  logic key_seen_r;

  logic [10:0] key_port;
  logic [7:0] key_val;
  logic twice;
  always_comb begin
    twice = port_sel_r;
    key_port = port_sel_r ? cfgreg_pkg::PORT_HIGH : cfgreg_pkg::PORT_LOW;
    case ({port_sel_r, reg_uart_ir_r[cfgreg_pkg::B_KEY_SEL]})
      2'b00: key_val = cfgreg_pkg::KEY_00;
      2'b01: key_val = cfgreg_pkg::KEY_01;
      2'b10: key_val = cfgreg_pkg::KEY_10;
      default: key_val = cfgreg_pkg::KEY_11;
    endcase
  end

  logic [10:0] data_port;
  logic key_wr;
  logic idx_wr;
  logic dat_wr;
  logic dat_rd;
  assign data_port = 11'(key_port + 11'h001);
  assign key_wr = wr_edge && sa_s == key_port;
  // index and data port decode while unlocked
  assign idx_wr = key_wr && unlocked_r;
  // lock blocks data port reads and writes
  assign dat_wr = wr_edge && unlocked_r && !lock_s && sa_s == data_port;
  assign dat_rd = !ior_s && !aen_s && unlocked_r && !lock_s &&
                  sa_s == data_port;

  // unlock sequence, single or double key write, exit on AAH
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      unlocked_r <= 1'b0;
      key_seen_r <= 1'b0;
    end else if (key_wr) begin
      if (unlocked_r) begin
        unlocked_r <= sd_s != cfgreg_pkg::KEY_EXIT;
        key_seen_r <= 1'b0;
      end else if (sd_s == key_val) begin
        unlocked_r <= !twice || key_seen_r;
        key_seen_r <= twice && !key_seen_r;
      end else begin
        key_seen_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      index_r <= 8'h00;
    end else if (idx_wr && sd_s != cfgreg_pkg::KEY_EXIT) begin
      index_r <= sd_s;
    end
  end

  // data port writes keep reserved bits zero; test registers ignored
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      reg_uart_ir_r <= cfgreg_pkg::RST_UART_IR;
      reg_ir_pin_r <= cfgreg_pkg::RST_IR_PIN;
      reg_gp0_lo_r <= cfgreg_pkg::RST_GP;
      reg_gp0_hi_r <= cfgreg_pkg::RST_GP;
      reg_gp1_lo_r <= cfgreg_pkg::RST_GP;
      reg_gp1_hi_r <= cfgreg_pkg::RST_GP;
      reg_gp0_mode_r <= cfgreg_pkg::RST_GP;
    end else if (dat_wr) begin
      case (index_r)
        cfgreg_pkg::IDX_UART_IR: reg_uart_ir_r <=
          sd_s & cfgreg_pkg::MASK_UART_IR;
        cfgreg_pkg::IDX_IR_PIN: reg_ir_pin_r <= sd_s;
        cfgreg_pkg::IDX_GP0_LO: reg_gp0_lo_r <= sd_s;
        cfgreg_pkg::IDX_GP0_HI: reg_gp0_hi_r <= sd_s & cfgreg_pkg::MASK_GP_HI;
        cfgreg_pkg::IDX_GP1_LO: reg_gp1_lo_r <= sd_s;
        cfgreg_pkg::IDX_GP1_HI: reg_gp1_hi_r <= sd_s & cfgreg_pkg::MASK_GP_HI;
        cfgreg_pkg::IDX_GP0_MODE: reg_gp0_mode_r <= sd_s;
        default: ;
      endcase
    end
  end

  // Readback mux; test and unmapped indices read zero
  logic [7:0] rd_data;
  always_comb begin
    case (index_r)
      cfgreg_pkg::IDX_UART_IR: rd_data = reg_uart_ir_r;
      cfgreg_pkg::IDX_IR_PIN: rd_data = reg_ir_pin_r;
      cfgreg_pkg::IDX_GP0_LO: rd_data = reg_gp0_lo_r;
      cfgreg_pkg::IDX_GP0_HI: rd_data = reg_gp0_hi_r;
      cfgreg_pkg::IDX_GP1_LO: rd_data = reg_gp1_lo_r;
      cfgreg_pkg::IDX_GP1_HI: rd_data = reg_gp1_hi_r;
      cfgreg_pkg::IDX_GP0_MODE: rd_data = reg_gp0_mode_r;
      default: rd_data = 8'h00;
    endcase
  end

  // Decoded general-purpose pins, one copy per pin
  logic [7:0] gp_mode [2];
  logic [10:0] gp_addr [2];
  logic [1:0] gp_cmp [2];
  logic [1:0] gp_rd_en;
  logic [1:0] gp_rd_bit;
  assign gp_mode[0] = reg_gp0_mode_r;
  assign gp_mode[1] = GP_ONE_MODE_I;
  assign gp_addr[0] = {reg_gp0_hi_r[2:0], reg_gp0_lo_r};
  assign gp_addr[1] = {reg_gp1_hi_r[2:0], reg_gp1_lo_r};
  assign gp_cmp[0] = reg_gp0_hi_r[7:6];
  assign gp_cmp[1] = reg_gp1_hi_r[7:6];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      logic [10:0] mask;
      logic hit;
      logic qual;
      logic sel_on;
      logic out_val_r;
      // drop low address bits from the compare
      assign mask = 11'h7ff << gp_cmp[gi];
      assign hit = !aen_s && ((sa_s ^ gp_addr[gi]) & mask) == 11'h000;
      // strobe qualifier: bit 2 write, bit 3 read
      assign qual = gp_mode[gi][3:2] == 2'b00 ||
                    (gp_mode[gi][2] && !iow_s) ||
                    (gp_mode[gi][3] && !ior_s);
      assign sel_on = hit && qual;
      // latch bus bit on matching write in output modes
      always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
          out_val_r <= 1'b0;
        end else if (wr_edge && hit && !gp_mode[gi][7] && gp_mode[gi][5]) begin
          out_val_r <= sd_s[gi] ^ gp_mode[gi][1];
        end
      end
      // chip select or data output drives the pin
      always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
          GP_PIN_O[gi] <= 1'b0;
          GP_PIN_OE_N_O[gi] <= 1'b1;
        end else if (gp_mode[gi][7]) begin
          GP_PIN_O[gi] <= sel_on ? gp_mode[gi][4] : !gp_mode[gi][4];
          GP_PIN_OE_N_O[gi] <= 1'b0;
        end else begin
          GP_PIN_O[gi] <= out_val_r;
          GP_PIN_OE_N_O[gi] <= !gp_mode[gi][5];
        end
      end
      // pin-to-bus inversion on matching reads only
      assign gp_rd_en[gi] = hit && !ior_s && !gp_mode[gi][7] &&
                            gp_mode[gi][6];
      assign gp_rd_bit[gi] = gpin_s[gi] ^ gp_mode[gi][0];
    end
  endgenerate

  // data bus drive; config read wins, unmatched cycles float
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      SD_O <= 8'h00;
      SD_OE_N_O <= 8'hff;
    end else if (dat_rd) begin
      SD_O <= rd_data;
      SD_OE_N_O <= 8'h00;
    end else begin
      SD_O <= {6'h00, gp_rd_bit};
      SD_OE_N_O <= {6'h3f, ~gp_rd_en};
    end
  end

  // clock selects straight from the register
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      UART_A_FAST_CLOCK_SEL_O <= 1'b0;
      UART_B_FAST_CLOCK_SEL_O <= 1'b0;
    end else begin
      UART_A_FAST_CLOCK_SEL_O <= reg_uart_ir_r[cfgreg_pkg::B_UART_A_FAST];
      UART_B_FAST_CLOCK_SEL_O <= reg_uart_ir_r[cfgreg_pkg::B_UART_B_FAST];
    end
  end

  // Infrared path
  logic [2:0] ir_mode;
  logic ir_role;
  logic ir_on;
  logic tx_v;
  logic tx_d_r;
  logic [3:0] phase_r;
  logic [7:0] pulse_cnt_r;
  logic [5:0] carr_cnt_r;
  logic carrier_r;
  logic [4:0] hold_r;
  logic bit_start;
  logic rx_ok;
  logic rx_v;
  // bank selection may override the register
  assign ir_mode = reg_uart_ir_r[cfgreg_pkg::B_BANK_PRI] ? BANK_IR_MODE_I :
                   reg_ir_pin_r[2:0];
  assign ir_role = !reg_uart_ir_r[cfgreg_pkg::B_ROLE];
  assign ir_on = ir_role && ir_mode[2:1] != 2'b00;
  assign tx_v = SECOND_SERIAL_OUT_I ^ reg_uart_ir_r[cfgreg_pkg::B_TX_INV];
  // A pulse starts each zero bit, counted in 16x ticks of the baud clock
  assign bit_start = !tx_v && (tx_d_r || (BAUD_X16_TICK_I &&
                     phase_r == 4'hf));

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      tx_d_r <= 1'b1;
      phase_r <= 4'h0;
    end else begin
      tx_d_r <= tx_v;
      if (tx_v) begin
        phase_r <= 4'h0;
      end else if (BAUD_X16_TICK_I) begin
        phase_r <= 4'(phase_r + 4'h1);
      end
    end
  end

  // pulse width: fixed cycles in 010, three ticks in 011
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      pulse_cnt_r <= 8'h00;
    end else if (bit_start && ir_mode == cfgreg_pkg::IRM_PULSE_FIX) begin
      pulse_cnt_r <= 8'(cfgreg_pkg::IR_PULSE_CYC);
    end else if (bit_start && ir_mode == cfgreg_pkg::IRM_PULSE_316) begin
      pulse_cnt_r <= cfgreg_pkg::PULSE_316_TICKS;
    end else if (pulse_cnt_r != 8'h00 &&
                 (ir_mode == cfgreg_pkg::IRM_PULSE_FIX ||
                  BAUD_X16_TICK_I)) begin
      pulse_cnt_r <= 8'(pulse_cnt_r - 8'h01);
    end
  end

  // carrier for odd shift-keyed modes; period is twice the half count
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      carr_cnt_r <= 6'h00;
      carrier_r <= 1'b0;
    end else if (carr_cnt_r == 6'(cfgreg_pkg::CARRIER_HALF_CYC - 1)) begin
      carr_cnt_r <= 6'h00;
      carrier_r <= !carrier_r;
    end else begin
      carr_cnt_r <= 6'(carr_cnt_r + 6'h01);
    end
  end

  assign rx_ok = reg_ir_pin_r[5:4] == 2'b01 || reg_ir_pin_r[5:4] == 2'b10;
  assign rx_v = (reg_ir_pin_r[5] ? infrared_receive_in_s[1] : infrared_receive_in_s[0]) ^
                reg_uart_ir_r[cfgreg_pkg::B_RX_INV];

  // received pulses stretch to one low bit time before the UART
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      hold_r <= 5'h00;
    end else if (rx_ok && rx_v) begin
      hold_r <= cfgreg_pkg::DEMOD_HOLD_TICKS;
    end else if (hold_r != 5'h00 && BAUD_X16_TICK_I) begin
      hold_r <= 5'(hold_r - 5'h01);
    end
  end

  // Serial input to the UART
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      SECOND_SERIAL_IN_O <= 1'b1;
    end else if (!ir_role) begin
      SECOND_SERIAL_IN_O <= sin_s ^ reg_uart_ir_r[cfgreg_pkg::B_RX_INV];
    end else if (!ir_on || !rx_ok) begin
      SECOND_SERIAL_IN_O <= 1'b1;
    end else if (reg_ir_pin_r[cfgreg_pkg::B_HALF_DUP] && !tx_v) begin
      // half duplex mutes receive while sending
      SECOND_SERIAL_IN_O <= 1'b1;
    end else if (ir_mode[1]) begin
      SECOND_SERIAL_IN_O <= hold_r == 5'h00;
    end else begin
      SECOND_SERIAL_IN_O <= rx_v;
    end
  end

  // Transmit value per mode; shift-keyed modes light on a zero bit
  logic ir_tx_val;
  always_comb begin
    if (!ir_mode[2]) begin
      ir_tx_val = pulse_cnt_r != 8'h00;
    end else begin
      ir_tx_val = !tx_v && (!ir_mode[0] || carrier_r);
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      INFRARED_TRANSMIT_OUT_O <= 2'b00;
      INFRARED_TRANSMIT_OE_N_O <= 2'b11;
      SERIAL_OUT_PIN_O <= 1'b1;
    end else begin
      INFRARED_TRANSMIT_OUT_O <= {2{ir_tx_val}};
      INFRARED_TRANSMIT_OE_N_O[0] <= !(ir_on && reg_ir_pin_r[7:6] == 2'b01);
      INFRARED_TRANSMIT_OE_N_O[1] <= !(ir_on && reg_ir_pin_r[7:6] == 2'b10);
      SERIAL_OUT_PIN_O <= ir_role ? 1'b1 : tx_v;
    end
  end

  // Checks
  property p_clk_sel;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    1'b1 |=> UART_A_FAST_CLOCK_SEL_O == $past(reg_uart_ir_r[7]);
  endproperty
  a_clk_sel: assert property (p_clk_sel)
    else $error("fast clock select does not follow register");

  property p_single_key;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    (key_wr && !unlocked_r && !twice && sd_s == key_val) |=> unlocked_r;
  endproperty
  a_single_key: assert property (p_single_key)
    else $error("single key did not unlock");

  property p_double_key;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    (key_wr && !unlocked_r && twice && !key_seen_r) |=> !unlocked_r;
  endproperty
  a_double_key: assert property (p_double_key)
    else $error("first of two key writes unlocked");

  property p_lock;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    (wr_edge && lock_s) |=> $stable(reg_ir_pin_r) && $stable(reg_gp0_mode_r);
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked write changed a register");

  property p_ir_off;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    (ir_role && ir_mode[2:1] == 2'b00) |=>
      INFRARED_TRANSMIT_OE_N_O == 2'b11 && SECOND_SERIAL_IN_O;
  endproperty
  a_ir_off: assert property (p_ir_off)
    else $error("disabled infrared still active");

  property p_route;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    (reg_ir_pin_r[7:6] != 2'b10) |=> INFRARED_TRANSMIT_OE_N_O[1];
  endproperty
  a_route: assert property (p_route)
    else $error("alternate transmit pin driven while not routed");

  property p_pulse_fix;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    (bit_start && ir_mode == cfgreg_pkg::IRM_PULSE_FIX && pulse_cnt_r == 0)
      |=> pulse_cnt_r == 8'd80;
  endproperty
  a_pulse_fix: assert property (p_pulse_fix)
    else $error("fixed pulse not 80 cycles");

  property p_cs_level;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    (gp_mode[0][7] && g_pin[0].sel_on) |=>
      !GP_PIN_OE_N_O[0] && GP_PIN_O[0] == $past(gp_mode[0][4]);
  endproperty
  a_cs_level: assert property (p_cs_level)
    else $error("chip select level wrong");

  property p_float;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    (gp_mode[0][7:5] == 3'b000) |=> GP_PIN_OE_N_O[0];
  endproperty
  a_float: assert property (p_float)
    else $error("inactive pin is driven");

  property p_cfg_read;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    dat_rd |=> SD_OE_N_O == 8'h00 && SD_O == $past(rd_data);
  endproperty
  a_cfg_read: assert property (p_cfg_read)
    else $error("config read data missing");

endmodule : cfgreg_top

// File: sim/cfgreg_host.sv
// Host bus master model issuing ISA I/O cycles to the bank
module cfgreg_host (
  input wire logic clk_i,
  input wire logic [7:0] sd_i,
  input wire logic [7:0] sd_oe_n_i,
  output logic [10:0] sa_o,
  output logic [7:0] sd_o,
  output logic ior_n_o,
  output logic iow_n_o,
  output logic aen_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus; AEN stays low because no DMA cycles run here
  initial begin
    sa_o = 11'h000;
    sd_o = 8'h00;
    ior_n_o = 1'b1;
    iow_n_o = 1'b1;
    aen_o = 1'b0;
  end
  // Every change lands 1 ns after a rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step
  task automatic io_wr(input logic [10:0] a, input logic [7:0] d);
    step(1);
    sa_o = a;
    sd_o = d;
    step(4);
    iow_n_o = 1'b0;
    step(6);
    iow_n_o = 1'b1;
    step(4);
    // Released data must not keep showing the last value
    sd_o = ~d;
  endtask : io_wr
  // Strobe spans the synchroniser delay before data is taken
  task automatic io_rd(input logic [10:0] a, output logic [7:0] d,
      output logic [7:0] oe_n);
    step(1);
    sa_o = a;
    step(4);
    ior_n_o = 1'b0;
    step(6);
    d = sd_i;
    oe_n = sd_oe_n_i;
    ior_n_o = 1'b1;
    step(5);
  endtask : io_rd
endmodule : cfgreg_host

// File: sim/cfgreg_top_test.sv
// Self-checking bench for the configuration register bank
`define CHK(got, exp) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module cfgreg_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic lock = 1'b0;
  logic strap = 1'b0;
  logic sout = 1'b0;
  logic [1:0] gp_in = 2'b01;
  logic [7:0] gp1_mode = 8'h00;
  logic [10:0] sa;
  logic [7:0] sd, sd_o, sd_oe_n, rd, oe;
  logic ior_n, iow_n, aen, ua, ub, sin, sopin;
  logic [1:0] gp_o, gp_oe_n, ir_o, ir_oe_n;
  int errors = 0;
  int checks_done = 0;
  localparam logic [10:0] DPORT = cfgreg_pkg::PORT_LOW + 11'h001;
  // 50 MHz system clock
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  cfgreg_top dut_u (.CLK_SYS_I(clk_sys), .RST_I(rst), .SA_I(sa), .SD_I(sd),
    .SD_O(sd_o), .SD_OE_N_O(sd_oe_n), .IOR_N_I(ior_n), .IOW_N_I(iow_n),
    .AEN_I(aen), .UNLOCK_PORT_SELECT_I(strap), .CONFIG_LOCK_I(lock),
    .GP_ONE_MODE_I(gp1_mode), .GP_PIN_I(gp_in), .GP_PIN_O(gp_o),
    .GP_PIN_OE_N_O(gp_oe_n), .UART_A_FAST_CLOCK_SEL_O(ua),
    .UART_B_FAST_CLOCK_SEL_O(ub), .BANK_IR_MODE_I(3'b000),
    .BAUD_X16_TICK_I(1'b0), .SECOND_SERIAL_OUT_I(sout),
    .SECOND_SERIAL_IN_O(sin), .SERIAL_IN_PIN_I(1'b1),
    .SERIAL_OUT_PIN_O(sopin), .INFRARED_RECEIVE_IN_I(2'b00),
    .INFRARED_TRANSMIT_OUT_O(ir_o), .INFRARED_TRANSMIT_OE_N_O(ir_oe_n));
  cfgreg_host host_u (.clk_i(clk_sys), .sd_i(sd_o), .sd_oe_n_i(sd_oe_n),
    .sa_o(sa), .sd_o(sd), .ior_n_o(ior_n), .iow_n_o(iow_n), .aen_o(aen));
  task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] v);
    host_u.io_wr(cfgreg_pkg::PORT_LOW, idx);
    host_u.io_wr(DPORT, v);
  endtask : cfg_wr
  // A refused read is judged on its enables; its data is meaningless
  task automatic cfg_rd(input logic [7:0] idx, input logic [7:0] exp,
      input logic [7:0] exp_oe);
    host_u.io_wr(cfgreg_pkg::PORT_LOW, idx);
    host_u.io_rd(DPORT, rd, oe);
    `CHK(oe, exp_oe)
    if (exp_oe === 8'h00) `CHK(rd, exp)
  endtask : cfg_rd
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    #1 rst = 1'b0;
    `CHK({ua, ub}, 2'b00)
    host_u.io_wr(cfgreg_pkg::PORT_LOW, cfgreg_pkg::KEY_01);
    cfg_rd(cfgreg_pkg::IDX_UART_IR, cfgreg_pkg::RST_UART_IR, 8'h00);
    cfg_rd(cfgreg_pkg::IDX_IR_PIN, cfgreg_pkg::RST_IR_PIN, 8'h00);
    cfg_rd(cfgreg_pkg::IDX_GP1_HI, 8'h00, 8'h00);
    `CHK({sopin, sin}, 2'b01)
    $display("test reset values done");
    cfg_wr(cfgreg_pkg::IDX_UART_IR, 8'hff);
    cfg_rd(cfgreg_pkg::IDX_UART_IR, 8'hfb, 8'h00);
    `CHK({ua, ub}, 2'b11)
    `CHK({sopin, sin}, 2'b10)
    cfg_wr(cfgreg_pkg::IDX_GP1_HI, 8'hff);
    cfg_rd(cfgreg_pkg::IDX_GP1_HI, 8'hc7, 8'h00);
    cfg_wr(cfgreg_pkg::IDX_TEST_A, 8'h00);
    cfg_rd(cfgreg_pkg::IDX_TEST_A, 8'h00, 8'h00);
    // Infrared role, register mode selection, key select kept
    cfg_wr(cfgreg_pkg::IDX_UART_IR, 8'h20);
    cfg_wr(cfgreg_pkg::IDX_IR_PIN, 8'h40);
    cfg_rd(cfgreg_pkg::IDX_IR_PIN, 8'h40, 8'h00);
    `CHK({ir_oe_n, sin}, 3'b111)
    cfg_wr(cfgreg_pkg::IDX_IR_PIN, 8'h54);
    `CHK({ir_oe_n, ir_o, sin}, 5'b10110)
    cfg_wr(cfgreg_pkg::IDX_IR_PIN, 8'h5c);
    `CHK(sin, 1'b1)
    // One zero bit in fixed pulse mode lights the output for 1.6 us
    cfg_wr(cfgreg_pkg::IDX_IR_PIN, 8'h52);
    sout = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 sout = 1'b0;
    repeat (cfgreg_pkg::IR_PULSE_CYC + 1) @(posedge clk_sys);
    #1 `CHK(ir_o, 2'b11)
    @(posedge clk_sys);
    #1 `CHK(ir_o, 2'b00)
    $display("test control fields done");
    cfg_wr(cfgreg_pkg::IDX_GP0_LO, 8'h34);
    cfg_wr(cfgreg_pkg::IDX_GP0_HI, 8'h03);
    cfg_wr(cfgreg_pkg::IDX_GP0_MODE, 8'h20);
    host_u.io_wr(11'h334, 8'h01);
    `CHK({gp_oe_n[0], gp_o[0]}, 2'b01)
    host_u.io_wr(11'h335, 8'h00);
    `CHK(gp_o[0], 1'b1)
    cfg_wr(cfgreg_pkg::IDX_GP0_HI, 8'h43);
    host_u.io_wr(11'h335, 8'h00);
    `CHK(gp_o[0], 1'b0)
    cfg_wr(cfgreg_pkg::IDX_GP0_MODE, 8'h22);
    host_u.io_wr(11'h334, 8'h00);
    `CHK(gp_o[0], 1'b1)
    cfg_wr(cfgreg_pkg::IDX_GP0_MODE, 8'h41);
    host_u.io_rd(11'h334, rd, oe);
    `CHK(oe, 8'hfe)
    `CHK(rd[0], 1'b0)
    cfg_wr(cfgreg_pkg::IDX_GP0_MODE, 8'h90);
    host_u.io_wr(11'h334, 8'h00);
    `CHK(gp_o[0], 1'b1)
    cfg_wr(cfgreg_pkg::IDX_GP0_MODE, 8'h80);
    host_u.io_wr(11'h334, 8'h00);
    `CHK(gp_o[0], 1'b0)
    cfg_wr(cfgreg_pkg::IDX_GP0_MODE, 8'h88);
    host_u.io_wr(11'h334, 8'h00);
    `CHK(gp_o[0], 1'b1)
    gp1_mode = 8'h20;
    host_u.io_wr(11'h702, 8'h02);
    `CHK({gp_oe_n[1], gp_o[1]}, 2'b01)
    $display("test pin decode done");
    lock = 1'b1;
    cfg_rd(cfgreg_pkg::IDX_UART_IR, 8'h00, 8'hff);
    lock = 1'b0;
    host_u.io_wr(cfgreg_pkg::PORT_LOW, cfgreg_pkg::KEY_EXIT);
    cfg_rd(cfgreg_pkg::IDX_UART_IR, 8'h00, 8'hff);
    $display("test lock and exit done");
    end_sim();
  end
  // Watchdog: the sequence needs about 1060 cycles
  initial begin
    #(5000 * 20);
    errors++;
    end_sim();
  end
endmodule : cfgreg_top_test
